/* File: rtl/pcm_loop.sv */
// Purpose: digital peak current mode loop for a step-down converter
// Assumes: sample converter, DAC and comparator are outside; all inputs synchronous
// Notes:   one sample and one filter update per switching period
//
// What this block does
// - Start one output-voltage conversion per period at a configurable trigger point.
// - Demand computed in one period is loaded as the ramp start value from the next period.
// - Filter result is multiplied by a programmable gain before becoming demand.
// - Output-voltage sample is an unsigned 12-bit code, 0 to 4095.
// - Demand DAC takes an unsigned 12-bit code, 4095 meaning full scale.
// - Error is the programmable setpoint minus the sample, same code scaling.
// - Comparator sees sensed current against DAC level; no sampling needed to trip.
// - Comparator trip resets the high-side output for the rest of the period.
// - Ramp loads the scaled demand from the previous period at each period start.
// - Each accepted ramp trigger lowers the DAC value by a programmable decrement, stopping at zero.
// - Ramp triggers come from the third compare unit, interval in timer ticks.
// - Ramp triggers sooner than the minimum update interval are ignored.
// - Reference setting gives 75 steps per 5 us period, about 66 ns each.
// - Each sample drives a two-pole two-zero difference equation.
`timescale 1ns/10ps
module pcm_loop
  import pcm_pkg::*;
#(
  parameter int MIN_UPD = MIN_UPD_CYC
)(
  input  wire logic               ref_clk,      // system clock
  input  wire logic               rst,          // sync reset, active high
  input  wire logic               enable,       // run the power stage
  input  wire logic [15:0]        periodTicks,  // switching period in ticks
  input  wire logic [15:0]        sampleAt,     // conversion trigger tick
  input  wire logic [15:0]        stepTicks,    // ramp compare interval in ticks
  input  wire logic [11:0]        setpoint,     // voltage setpoint code
  input  wire logic [11:0]        rampStep,     // decrement per ramp step
  input  wire logic signed [15:0] gainK,        // loop gain, Q2.14
  input  wire logic signed [15:0] coefA1,       // filter coefficient a1
  input  wire logic signed [15:0] coefA2,       // filter coefficient a2
  input  wire logic signed [15:0] coefB0,       // filter coefficient b0
  input  wire logic signed [15:0] coefB1,       // filter coefficient b1
  input  wire logic signed [15:0] coefB2,       // filter coefficient b2
  input  wire logic               convDone,     // sample valid strobe
  input  wire logic [11:0]        convData,     // sampled voltage code
  input  wire logic               peakTrip,     // comparator output
  output logic                    convStart,    // conversion start pulse
  output logic [11:0]             dacCode,      // demand level to DAC
  output logic                    hsPwm,        // high-side switch drive
  output logic                    periodStart   // period start pulse
);
  typedef enum logic [1:0] {
    PCM_IDLE = 2'b00,
    PCM_WAIT = 2'b01,
    PCM_CALC = 2'b10
  } pcm_state_t;

  logic [15:0]        tickReg, tickNext;
  logic [15:0]        cmpReg, cmpNext;
  logic [15:0]        gapReg, gapNext;
  logic [11:0]        dacReg, dacNext;
  logic [11:0]        demandReg, demandNext;
  logic               pwmReg, pwmNext;
  logic               startReg, startNext;
  logic               convReg, convNext;
  logic               sampledReg, sampledNext;
  pcm_state_t         stateReg, stateNext;
  logic signed [12:0] e0Reg, e0Next, e1Reg, e1Next, e2Reg, e2Next;
  logic signed [ACC_W-1:0] y1Reg, y1Next, y2Reg, y2Next;
  logic signed [ACC_W-1:0] accW, scaled;
  logic               endOfPeriod, stepTrig;
  logic [11:0]        dacDec;

  assign endOfPeriod = tickReg >= periodTicks - 16'h0001;
  assign stepTrig    = cmpReg >= stepTicks - 16'h0001;

  function automatic logic [11:0] sat12(input logic signed [ACC_W-1:0] v);
    if (v < 0)
      sat12 = CODE_MIN;
    else if (v > ACC_W'(CODE_MAX))
      sat12 = CODE_MAX;
    else
      sat12 = v[11:0];
  endfunction

  always_comb
  begin
    // y[n] = a1*y1 + a2*y2 + b0*e0 + b1*e1 + b2*e2, filter state kept unscaled
    accW = (ACC_W'(coefA1) * y1Reg + ACC_W'(coefA2) * y2Reg
          + ACC_W'(coefB0) * ACC_W'(e0Reg) + ACC_W'(coefB1) * ACC_W'(e1Reg)
          + ACC_W'(coefB2) * ACC_W'(e2Reg)) >>> COEF_FRAC;
    scaled = (accW * ACC_W'(gainK)) >>> COEF_FRAC;
    dacDec = (dacReg > rampStep) ? dacReg - rampStep : CODE_MIN;
  end

  always_comb
  begin
    tickNext    = endOfPeriod ? 16'h0000 : tickReg + 16'h0001;
    startNext   = enable && endOfPeriod;
    convNext    = enable && (tickReg == sampleAt) && !sampledReg;
    sampledNext = endOfPeriod ? 1'b0 : (sampledReg || convNext);
    cmpNext     = cmpReg + 16'h0001;
    gapNext     = (gapReg == 16'hFFFF) ? gapReg : gapReg + 16'h0001;
    dacNext     = dacReg;
    pwmNext     = pwmReg;
    if (endOfPeriod)
    begin
      dacNext = demandReg;
      pwmNext = enable;
      cmpNext = 16'h0000;
      gapNext = 16'h0000;
    end
    else
    begin
      if (stepTrig)
      begin
        cmpNext = 16'h0000;
        if (gapReg >= 16'(MIN_UPD - 1))
        begin
          dacNext = dacDec;
          gapNext = 16'h0000;
        end
      end
      if (peakTrip || !enable)
        pwmNext = 1'b0;
    end
  end

  always_comb
  begin
    stateNext  = stateReg;
    demandNext = demandReg;
    e0Next = e0Reg;
    e1Next = e1Reg;
    e2Next = e2Reg;
    y1Next = y1Reg;
    y2Next = y2Reg;
    case (stateReg)
      PCM_IDLE:
        if (enable)
          stateNext = PCM_WAIT;
      PCM_WAIT:
        if (!enable)
          stateNext = PCM_IDLE;
        else if (convDone)
        begin
          e2Next = e1Reg;
          e1Next = e0Reg;
          e0Next = $signed({1'b0, setpoint}) - $signed({1'b0, convData});
          stateNext = PCM_CALC;
        end
      PCM_CALC:
      begin
        y2Next     = y1Reg;
        y1Next     = accW;
        demandNext = sat12(scaled);
        stateNext  = PCM_WAIT;
      end
      default:
        stateNext = PCM_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tickReg <= 16'h0000;
      cmpReg <= 16'h0000;
      gapReg <= 16'h0000;
      dacReg <= DEMAND_RST;
      demandReg <= DEMAND_RST;
      pwmReg <= 1'b0;
      startReg <= 1'b0;
      convReg <= 1'b0;
      sampledReg <= 1'b0;
      stateReg <= PCM_IDLE;
      e0Reg <= 13'sh0000;
      e1Reg <= 13'sh0000;
      e2Reg <= 13'sh0000;
      y1Reg <= '0;
      y2Reg <= '0;
    end
    else
    begin
      tickReg <= tickNext;
      cmpReg <= cmpNext;
      gapReg <= gapNext;
      dacReg <= dacNext;
      demandReg <= demandNext;
      pwmReg <= pwmNext;
      startReg <= startNext;
      convReg <= convNext;
      sampledReg <= sampledNext;
      stateReg <= stateNext;
      e0Reg <= e0Next;
      e1Reg <= e1Next;
      e2Reg <= e2Next;
      y1Reg <= y1Next;
      y2Reg <= y2Next;
    end
  end

  assign convStart   = convReg;
  assign dacCode     = dacReg;
  assign hsPwm       = pwmReg;
  assign periodStart = startReg;

  property p_one_conv;
    @(posedge ref_clk) disable iff (rst)
      convStart |=> !convStart;
  endproperty
  a_one_conv: assert property (p_one_conv) else $error("conversion start not one cycle");

  property p_load;
    @(posedge ref_clk) disable iff (rst)
      endOfPeriod |=> dacCode == $past(demandReg);
  endproperty
  a_load: assert property (p_load) else $error("ramp did not load demand");

  property p_trip;
    @(posedge ref_clk) disable iff (rst)
      (peakTrip && !endOfPeriod) |=> !hsPwm;
  endproperty
  a_trip: assert property (p_trip) else $error("trip did not clear high side");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
      (!endOfPeriod && !stepTrig) |=> $stable(dacCode);
  endproperty
  a_hold: assert property (p_hold) else $error("dac changed without trigger");

  property p_dec;
    @(posedge ref_clk) disable iff (rst)
      (!endOfPeriod && stepTrig && gapReg >= 16'(MIN_UPD - 1) && dacReg > rampStep)
        |=> dacCode == $past(dacReg) - $past(rampStep);
  endproperty
  a_dec: assert property (p_dec) else $error("ramp step wrong");

  property p_gap;
    @(posedge ref_clk) disable iff (rst)
      (!endOfPeriod && stepTrig && gapReg < 16'(MIN_UPD - 1)) |=> $stable(dacCode);
  endproperty
  a_gap: assert property (p_gap) else $error("early ramp trigger accepted");

  property p_nowrap;
    @(posedge ref_clk) disable iff (rst)
      (!endOfPeriod && stepTrig) |=> dacCode <= $past(dacReg);
  endproperty
  a_nowrap: assert property (p_nowrap) else $error("ramp wrapped");

  property p_start;
    @(posedge ref_clk) disable iff (rst)
      periodStart |-> (hsPwm == enable);
  endproperty
  a_start: assert property (p_start) else $error("high side not set at start");

  sequence s_calc_enter;
    stateReg == PCM_CALC;
  endsequence

  sequence s_calc_leave;
    stateReg != PCM_CALC;
  endsequence

  property p_calc;
    @(posedge ref_clk) disable iff (rst)
      (stateReg == PCM_WAIT && enable && convDone) |=> s_calc_enter ##1 s_calc_leave;
  endproperty
  a_calc: assert property (p_calc) else $error("filter update missing");
endmodule

/* File: rtl/pcm_pkg.sv */
// Purpose: shared constants for the peak current mode control loop
// Assumes: 125 MHz ref_clk, 12-bit sample and demand codes
// Notes:   coefficient and gain fields are signed Q2.14 fixed point
package pcm_pkg;
  localparam int          CODE_W        = 12;
  localparam int          COEF_W        = 16;
  localparam int          COEF_FRAC     = 14;
  localparam int          ACC_W         = 40;
  localparam logic [11:0] CODE_MAX      = 12'hFFF;
  localparam logic [11:0] CODE_MIN      = 12'h000;
  localparam int          CLK_MHZ       = 125;
  localparam int          PERIOD_NS     = 5000;
  localparam int          PERIOD_CYC    = PERIOD_NS * CLK_MHZ / 1000;
  localparam int          STEPS_PER_PER = 75;
  localparam int          STEP_NS       = 66;
  localparam int          STEP_CYC      = STEP_NS * CLK_MHZ / 1000;
  localparam int          MIN_UPD_NS    = 66;
  // rounded down so the reference step interval is never refused
  localparam int          MIN_UPD_CYC   = MIN_UPD_NS * CLK_MHZ / 1000;
  localparam logic [15:0] PERIOD_RST    = 16'(PERIOD_CYC);
  localparam logic [15:0] STEP_RST      = 16'(STEP_CYC);
  localparam logic [11:0] DEMAND_RST    = 12'h000;
endpackage

/* File: testbench/pcm_stage_model.sv */
// Purpose: behavioural power stage, voltage sampler and peak comparator
// Assumes: latency in clocks, inductor current in DAC code units
// Notes:   convData shows the inverted last code outside its strobe
`timescale 1ns/10ps
module pcm_stage_model #(
  parameter int LAT = 5
)(
  input  wire logic        ref_clk,   // system clock
  input  wire logic        convStart, // conversion start
  input  wire logic [11:0] vout,      // voltage code to report
  input  wire logic [11:0] dacCode,   // demand level
  input  wire logic        hsPwm,     // high-side drive
  output logic             convDone,  // sample strobe
  output logic [11:0]      convData,  // sample code
  output logic             peakTrip   // comparator output
);
  int          cnt  = 0;
  logic [11:0] last = 12'h000;
  logic [12:0] iL   = 13'h0000;
  always @(posedge ref_clk)
  begin
    convDone <= (cnt == 1);
    convData <= (cnt == 1) ? vout : ~last;
    if (cnt == 1)
      last <= vout;
    cnt <= convStart ? LAT : (cnt > 0 ? cnt - 1 : 0);
    iL  <= hsPwm ? iL + 13'h0040 : (iL > 13'h0020 ? iL - 13'h0020 : 13'h0000);
  end
  // sensed current against the demand level
  assign peakTrip = (iL >= {1'b0, dacCode});
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the peak current mode loop
// Assumes: 80-cycle period and MIN_UPD of 6 keep the run short
// Notes:   coefficients are powers of two so expected demands are exact sums
`timescale 1ns/10ps
module tb_top;
  import pcm_pkg::*;
  logic               ref_clk = 1'b0, rst = 1'b1, enable = 1'b0;
  logic               convDone, peakTrip, convStart, hsPwm, periodStart;
  logic [15:0]        periodTicks = 16'h0050, sampleAt = 16'h0010, stepTicks = 16'h0008;
  logic [11:0]        setpoint = 12'h800, rampStep = 12'h010, vout = 12'h300;
  logic [11:0]        convData, dacCode;
  logic signed [15:0] gainK = 16'h4000, coefB0 = 16'h4000, coefB1 = 16'h0000;
  logic signed [15:0] coefA1 = 16'h0000, coefA2 = 16'h0000, coefB2 = 16'h0000;
  int                 fail_count = 0, check_count = 0;
  always #4 ref_clk = ~ref_clk;
  pcm_loop #(.MIN_UPD(6)) DUT (.ref_clk(ref_clk), .rst(rst), .enable(enable),
    .periodTicks(periodTicks), .sampleAt(sampleAt), .stepTicks(stepTicks),
    .setpoint(setpoint), .rampStep(rampStep), .gainK(gainK), .coefA1(coefA1),
    .coefA2(coefA2), .coefB0(coefB0), .coefB1(coefB1), .coefB2(coefB2),
    .convDone(convDone), .convData(convData), .peakTrip(peakTrip), .convStart(convStart),
    .dacCode(dacCode), .hsPwm(hsPwm), .periodStart(periodStart));
  pcm_stage_model #(.LAT(5)) stage (.ref_clk(ref_clk), .convStart(convStart), .vout(vout),
    .dacCode(dacCode), .hsPwm(hsPwm), .convDone(convDone), .convData(convData),
    .peakTrip(peakTrip));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic to_period();
    int n;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
    end while (periodStart !== 1'b1 && n < 1000);
    if (periodStart !== 1'b1)
      fail_count++;
  endtask
  // one conversion per period, its start pulse sampleAt+1 ticks after the period start pulse
  task automatic t_period(input logic [15:0] sa);
    int at, n, hits;
    sampleAt = sa;
    repeat (2) to_period();
    at = 0;
    hits = 0;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (convStart === 1'b1)
        hits++;
      if (convStart === 1'b1)
        at = n;
    end while (periodStart !== 1'b1 && n < 1000);
    chk(16'(at), sa + 16'h0001);
    chk(16'(hits), 16'h0001);
    chk(16'(n), periodTicks);
  endtask
  task automatic t_demand(input logic [11:0] sp, v, input logic [15:0] k, b1, exp);
    setpoint = sp;
    vout = v;
    gainK = k;
    coefB1 = b1;
    repeat (3) to_period();
    chk(16'(dacCode), exp);
  endtask
  // exercises the older error and both output history terms
  task automatic t_filter(input logic [11:0] sp, input logic [15:0] a1, a2, b0, b2, exp);
    setpoint = sp;
    coefA1 = a1;
    coefA2 = a2;
    coefB0 = b0;
    coefB2 = b2;
    repeat (3) to_period();
    chk(16'(dacCode), exp);
  endtask
  // every change inside a period is one decrement, spaced by the accepted interval
  task automatic t_ramp(input logic [15:0] st, input logic [11:0] rs, input int gap);
    int n, last;
    logic [11:0] prev;
    stepTicks = st;
    rampStep = rs;
    repeat (2) to_period();
    prev = dacCode;
    last = -1;
    n = 0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (dacCode !== prev && periodStart !== 1'b1)
      begin
        chk(16'(dacCode), 16'(prev > rs ? prev - rs : 12'h000));
        if (last >= 0)
          chk(16'(n - last), 16'(gap));
        last = n;
        prev = dacCode;
      end
    end while (periodStart !== 1'b1 && n < 1000);
    chk(16'(last > 0), 16'h0001);
  endtask
  task automatic t_trip();
    int n, hi;
    to_period();
    n = 0;
    hi = 0;
    while (!(peakTrip === 1'b1 && hsPwm === 1'b1) && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    chk(16'(hsPwm), 16'h0000);
    while (periodStart !== 1'b1 && n < 1000)
    begin
      @(negedge ref_clk);
      n++;
      if (hsPwm === 1'b1 && periodStart !== 1'b1)
        hi++;
    end
    chk(16'(hi), 16'h0000);
    chk(16'(hsPwm), 16'h0001);
  endtask
  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    enable = 1'b1;
    t_period(16'h0010);
    t_period(16'h0030);
    t_demand(12'h800, 12'h300, 16'h4000, 16'h0000, 16'h0500);
    t_demand(12'h500, 12'h300, 16'h6000, 16'h0000, 16'h0300);
    t_demand(12'hF00, 12'h300, 16'h6000, 16'h0000, 16'h0FFF);
    t_demand(12'h300, 12'h800, 16'h4000, 16'h0000, 16'h0000);
    t_demand(12'h500, 12'h300, 16'h4000, 16'h4000, 16'h0400);
    t_demand(12'h800, 12'h300, 16'h4000, 16'h0000, 16'h0500);
    t_filter(12'h600, 16'h0000, 16'h0000, 16'h0000, 16'h4000, 16'h0300);
    t_filter(12'h600, 16'h2000, 16'h2000, 16'h0000, 16'h0000, 16'h03C0);
    t_filter(12'h800, 16'h0000, 16'h0000, 16'h4000, 16'h0000, 16'h0500);
    t_ramp(16'h0008, 12'h010, 8);
    t_ramp(16'h0003, 12'h010, 6);
    t_ramp(16'h0008, 12'h0C0, 8);
    t_trip();
    conclude();
  end
  initial
  begin
    #400000;
    fail_count++;
    conclude();
  end
endmodule
